// ==== rtc_control_status_irq_regs.sv ====
// Overview of operation
// - Control bit 7 keeps counting during standby.
// - Bits 6:3 divide counter clock by power-of-two.
// - Control write acts after two counter-clock cycles.
// - Control bit 2 enables frequency correction.
// - Control bit 0 enables the counter.
// - Status bit 3 shows compare transfer busy.
// - Status bit 2 shows wrap-limit transfer busy.
// - Status bit 1 shows count transfer busy.
// - Status bit 0 shows control transfer busy.
// - Enable bit 1 gates compare-match interrupt.
// - Enable bit 0 gates wrap interrupt.
// - Counter wraps to zero after wrap limit.
// - Flag bit 1 sets on count equal compare.
// - Flag bit 0 sets on wrap to zero.
// - Writing one clears a flag, zero keeps.
// - Staging byte gives atomic 16-bit access.
// - One staging byte shared, directly readable, writable.
// - Interrupt asserted while flag and enable set.
// - Counter-clock transfers are synchronized.
`timescale 1ns/1ns
`default_nettype none
module rtc_control_status_irq_regs
  import rtc_regs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        counter_clock,
  input  wire logic        standby_sleep,
  output logic             irq,
  output logic             freq_correction_enable
);

  // ---------------------------------------------------------------
  // State.
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                       ack;
    logic [7:0]                 rdat;
    logic [7:0]                 counter_control;
    logic [7:0]                 ctrl_act;
    logic [1:0]                 interrupt_enable;
    logic [1:0]                 interrupt_flags;
    logic [7:0]                 staging;
    logic [15:0]                wrap_limit;
    logic [15:0]                wrap_act;
    logic [15:0]                cmp_val;
    logic [15:0]                cmp_act;
    logic [15:0]                cnt_new;
    logic [15:0]                tick_count;
    logic [SYN_N-1:0]           busy;
    logic [SYN_N-1:0][1:0]      sync_cnt;
    logic                       clk_s1;
    logic                       clk_s2;
    logic                       clk_s3;
    logic [PSC_W-1:0]           psc;
    logic                       irq;
    logic                       corr;
  } state_s;

  state_s q;
  state_s d;

  logic             access;
  logic             wr;
  logic             rd;
  logic [5:0]       idx;
  logic [7:0]       wdat;
  logic             slow_edge;
  logic             run;
  logic             pre_tick;
  logic [PSC_W-1:0] psc_mask;
  logic [15:0]      next_count;

  // ---------------------------------------------------------------
  // Bus decode and counter clock tick.
  // ---------------------------------------------------------------
  assign access    = wb_cyc_i && wb_stb_i && !q.ack;
  assign wr        = access && wb_we_i && wb_sel_i[0];
  assign rd        = access && !wb_we_i;
  assign idx       = wb_adr_i[7:2];
  assign wdat      = wb_dat_i[7:0];
  assign slow_edge = q.clk_s2 && !q.clk_s3;
  assign run       = q.ctrl_act[CTRL_EN_BIT]
                     && (!standby_sleep || q.ctrl_act[CTRL_STDBY_BIT]);
  assign psc_mask  = PSC_W'((16'h0001
                     << q.ctrl_act[CTRL_PSC_MSB:CTRL_PSC_LSB]) - 16'h0001);
  assign pre_tick  = slow_edge && run && ((q.psc & psc_mask) == psc_mask);
  assign next_count = (q.tick_count == q.wrap_act) ? COUNT_RESET
                      : q.tick_count + 16'h0001;

  // ---------------------------------------------------------------
  // Next state.
  // ---------------------------------------------------------------
  always_comb begin
    logic [1:0] flag_set;
    logic [1:0] flag_clr;
    d        = q;
    flag_set = 2'b00;
    flag_clr = 2'b00;

    d.clk_s1 = counter_clock;
    d.clk_s2 = q.clk_s1;
    d.clk_s3 = q.clk_s2;
    d.ack    = access;

    // Prescaler and counter.
    if (slow_edge && run) begin
      d.psc = q.psc + PSC_W'(1);
    end
    if (pre_tick) begin
      d.tick_count = next_count;
      if (q.tick_count == q.wrap_act) begin
        flag_set[FLAG_WRAP] = 1'b1;
      end
      if (next_count == q.cmp_act) begin
        flag_set[FLAG_CMP] = 1'b1;
      end
    end

    // Transfers into the counter domain complete after two ticks.
    for (int i = 0; i < SYN_N; i++) begin
      if (q.busy[i] && slow_edge) begin
        d.sync_cnt[i] = q.sync_cnt[i] + 2'h1;
        if (q.sync_cnt[i] + 2'h1 == SYNC_TICKS) begin
          d.busy[i] = 1'b0;
        end
      end
    end
    if (q.busy[SYN_CTRL] && !d.busy[SYN_CTRL]) begin
      d.ctrl_act = q.counter_control;
    end
    if (q.busy[SYN_WRAP] && !d.busy[SYN_WRAP]) begin
      d.wrap_act = q.wrap_limit;
    end
    if (q.busy[SYN_CMP] && !d.busy[SYN_CMP]) begin
      d.cmp_act = q.cmp_val;
    end
    if (q.busy[SYN_CNT] && !d.busy[SYN_CNT]) begin
      d.tick_count = q.cnt_new;
      d.psc        = '0;
    end

    // Register reads, with the staging side effect on 16-bit low bytes.
    if (rd) begin
      case (idx)
        IDX_CONTROL:   d.rdat = q.counter_control;
        IDX_STATUS:    d.rdat = {4'h0, q.busy};
        IDX_INT_EN:    d.rdat = {6'h00, q.interrupt_enable};
        IDX_INT_FLAGS: d.rdat = {6'h00, q.interrupt_flags};
        IDX_STAGING:   d.rdat = q.staging;
        IDX_COUNT_LO: begin
          d.rdat    = q.tick_count[7:0];
          d.staging = q.tick_count[15:8];
        end
        IDX_WRAP_LO: begin
          d.rdat    = q.wrap_limit[7:0];
          d.staging = q.wrap_limit[15:8];
        end
        IDX_CMP_LO: begin
          d.rdat    = q.cmp_val[7:0];
          d.staging = q.cmp_val[15:8];
        end
        IDX_COUNT_HI,
        IDX_WRAP_HI,
        IDX_CMP_HI:    d.rdat = q.staging;
        default:       d.rdat = 8'h00;
      endcase
    end else if (access) begin
      d.rdat = 8'h00;
    end

    // Register writes; a high byte write commits {data, staging}.
    if (wr) begin
      case (idx)
        IDX_CONTROL: begin
          d.counter_control = wdat & CTRL_WMASK;
          d.busy[SYN_CTRL]     = 1'b1;
          d.sync_cnt[SYN_CTRL] = 2'h0;
        end
        IDX_INT_EN:    d.interrupt_enable = wdat[1:0];
        IDX_INT_FLAGS: flag_clr = wdat[1:0];
        IDX_STAGING,
        IDX_COUNT_LO,
        IDX_WRAP_LO,
        IDX_CMP_LO:    d.staging = wdat;
        IDX_COUNT_HI: begin
          d.cnt_new           = {wdat, q.staging};
          d.busy[SYN_CNT]     = 1'b1;
          d.sync_cnt[SYN_CNT] = 2'h0;
        end
        IDX_WRAP_HI: begin
          d.wrap_limit         = {wdat, q.staging};
          d.busy[SYN_WRAP]     = 1'b1;
          d.sync_cnt[SYN_WRAP] = 2'h0;
        end
        IDX_CMP_HI: begin
          d.cmp_val           = {wdat, q.staging};
          d.busy[SYN_CMP]     = 1'b1;
          d.sync_cnt[SYN_CMP] = 2'h0;
        end
        default: begin
        end
      endcase
    end

    // A hardware set in the clearing cycle wins.
    d.interrupt_flags = (q.interrupt_flags & ~flag_clr) | flag_set;
    d.irq  = |(d.interrupt_flags & d.interrupt_enable);
    d.corr = d.ctrl_act[CTRL_CORR_BIT];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q                 <= '0;
      q.counter_control <= CTRL_RESET;
      q.ctrl_act        <= CTRL_RESET;
      q.wrap_limit      <= WRAP_RESET;
      q.wrap_act        <= WRAP_RESET;
      q.cmp_val         <= CMP_RESET;
      q.cmp_act         <= CMP_RESET;
      q.tick_count      <= COUNT_RESET;
    end else begin
      q <= d;
    end
  end

  assign wb_dat_o               = {24'h000000, q.rdat};
  assign wb_ack_o               = q.ack;
  assign irq                    = q.irq;
  assign freq_correction_enable = q.corr;

  // ---------------------------------------------------------------
  // Check helpers.
  // ---------------------------------------------------------------
  // Counter-clock edges seen since the last wrap-limit commit; it
  // saturates so that a long idle spell never brings it back to two.
  logic [1:0] wrap_edges_q;

  always_ff @(posedge clk) begin
    if (!rst_n || (wr && idx == IDX_WRAP_HI)) begin
      wrap_edges_q <= 2'h0;
    end else if (slow_edge && wrap_edges_q != 2'h3) begin
      wrap_edges_q <= wrap_edges_q + 2'h1;
    end
  end

  // ---------------------------------------------------------------
  // Checks.
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_write(logic [5:0] a);
    wr && idx == a;
  endsequence

  sequence s_read(logic [5:0] a);
    rd && idx == a;
  endsequence

  sequence s_count_step;
    pre_tick && !q.busy[SYN_CNT];
  endsequence

  AST_CTRL_BUSY_SET: assert property (
    s_write(IDX_CONTROL) |=> q.busy[SYN_CTRL])
    else $error("control busy not raised by write");
  AST_CTRL_COMMIT: assert property (
    $fell(q.busy[SYN_CTRL]) |-> q.ctrl_act == q.counter_control)
    else $error("control copy not committed at busy clear");
  AST_CTRL_NOT_EARLY: assert property (
    s_write(IDX_CONTROL) ##1 slow_edge |=> q.busy[SYN_CTRL])
    else $error("control busy cleared after one tick");
  AST_CMP_BUSY: assert property (
    s_write(IDX_CMP_HI) |=> q.busy[SYN_CMP])
    else $error("compare busy not raised");
  AST_WRAP_BUSY: assert property (
    wrap_edges_q == SYNC_TICKS |-> !q.busy[SYN_WRAP])
    else $error("wrap busy not cleared after two ticks");
  AST_CNT_LOAD: assert property (
    $fell(q.busy[SYN_CNT]) |-> q.tick_count == q.cnt_new)
    else $error("count not loaded at busy clear");
  AST_WRAP_ZERO: assert property (
    pre_tick && q.tick_count == q.wrap_act && !q.busy[SYN_CNT]
    |=> q.tick_count == COUNT_RESET && q.interrupt_flags[FLAG_WRAP])
    else $error("wrap did not return to zero with flag");
  AST_W1C: assert property (
    s_write(IDX_INT_FLAGS) ##0 (wdat[FLAG_CMP] && !pre_tick)
    |=> !q.interrupt_flags[FLAG_CMP])
    else $error("compare flag not cleared by one");
  AST_IRQ: assert property (
    (q.interrupt_flags & q.interrupt_enable) != 2'b00 |-> q.irq)
    else $error("interrupt not asserted");
  AST_STOPPED: assert property (
    !run && !q.busy[SYN_CNT] |=> $stable(q.tick_count))
    else $error("counter moved while stopped");
  AST_STATUS_UPPER: assert property (
    s_read(IDX_STATUS) |=> q.rdat[7:4] == 4'h0)
    else $error("status upper bits not zero");
  AST_CTRL_BIT1: assert property (
    s_write(IDX_CONTROL) |=> (q.counter_control & ~CTRL_WMASK) == 8'h00)
    else $error("control reserved bit stored");
  AST_FLAG_HOLD: assert property (
    s_write(IDX_INT_FLAGS)
    ##0 (!wdat[FLAG_WRAP] && q.interrupt_flags[FLAG_WRAP])
    |=> q.interrupt_flags[FLAG_WRAP])
    else $error("wrap flag cleared by zero");
  AST_CMP_FLAG: assert property (
    s_count_step ##0 (next_count == q.cmp_act)
    |=> q.interrupt_flags[FLAG_CMP])
    else $error("compare flag not set on match");
  AST_STAGING_LO: assert property (
    s_read(IDX_COUNT_LO) |=> q.staging == $past(q.tick_count[15:8]))
    else $error("staging not loaded with count high byte");
  AST_HI_COMMIT: assert property (
    s_write(IDX_CMP_HI) |=> q.cmp_val == {$past(wdat), $past(q.staging)})
    else $error("compare not committed from staging pair");
  AST_STAGING_RW: assert property (
    s_write(IDX_STAGING) |=> q.staging == $past(wdat))
    else $error("staging write lost");
  AST_INT_EN_WR: assert property (
    s_write(IDX_INT_EN) |=> q.interrupt_enable == $past(wdat[1:0]))
    else $error("interrupt enable write lost");
  AST_CORR: assert property (
    $fell(q.busy[SYN_CTRL])
    |-> q.corr == q.counter_control[CTRL_CORR_BIT])
    else $error("correction enable not following control");
  AST_IRQ_LOW: assert property (
    (q.interrupt_flags & q.interrupt_enable) == 2'b00 |-> !q.irq)
    else $error("interrupt asserted without enabled flag");
  AST_STEP_DIV1: assert property (
    slow_edge && run && q.ctrl_act[CTRL_PSC_MSB:CTRL_PSC_LSB] == 4'h0
    && !q.busy[SYN_CNT] && q.tick_count != q.wrap_act
    |=> q.tick_count == $past(q.tick_count) + 16'h0001)
    else $error("undivided counter missed a step");
  AST_RUN_DIV: assert property (
    slow_edge && run && (q.psc & psc_mask) != psc_mask && !q.busy[SYN_CNT]
    |=> $stable(q.tick_count))
    else $error("divided counter stepped early");

endmodule : rtc_control_status_irq_regs
`default_nettype wire

// ==== rtc_control_status_irq_regs_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
module rtc_control_status_irq_regs_bench;
  import rtc_regs_pkg::*;

  logic        clk;
  logic        rst_n;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        counter_clock;
  logic        standby_sleep;
  logic        irq;
  logic        freq_correction_enable;
  logic [7:0]  rd;
  logic [2:0]  div_q;
  int          n_errors;
  int          compares;

  rtc_control_status_irq_regs dut (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .counter_clock(counter_clock), .standby_sleep(standby_sleep),
    .irq(irq), .freq_correction_enable(freq_correction_enable)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // Slow counter clock, one period every eight bus cycles.
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      div_q         <= 3'h0;
      counter_clock <= 1'b0;
    end else begin
      div_q <= div_q + 3'h1;
      if (div_q[1:0] == 2'h3) begin
        counter_clock <= ~counter_clock;
      end
    end
  end

  task automatic conclude();
    if (n_errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string name, input logic [7:0] exp,
                     input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic bus(input logic we, input logic [5:0] idx,
                     input logic [7:0] wd, input logic [3:0] sel);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= sel;
    wb_dat_i <= {24'h000000, wd};
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_errors++;
      $display("ERROR bus_ack expected 1 seen %b", wb_ack_o);
    end
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 4'h1);
  endtask : wr

  task automatic rdc(input string name, input logic [5:0] idx,
                     input logic [7:0] exp);
    bus(1'b0, idx, 8'h00, 4'h1);
    chk(name, exp, rd);
  endtask : rdc

  // Polls the busy flags until every crossing has finished.
  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      bus(1'b0, IDX_STATUS, 8'h00, 4'h1);
      k++;
    end while (rd !== 8'h00 && k < 40);
    if (k >= 40) begin
      n_errors++;
      $display("ERROR status_idle expected 00 seen %h", rd);
    end
  endtask : wait_idle

  task automatic ctrl(input logic [7:0] d);
    wr(IDX_CONTROL, d);
    wait_idle();
  endtask : ctrl

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    conclude();
  end

  initial begin
    n_errors = 0;
    compares = 0;
    rst_n = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h00000000;
    standby_sleep = 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdc("control", IDX_CONTROL, 8'h00);
    rdc("status", IDX_STATUS, 8'h00);
    rdc("int_enable", IDX_INT_EN, 8'h00);
    rdc("int_flags", IDX_INT_FLAGS, 8'h00);
    rdc("wrap_lo", IDX_WRAP_LO, 8'hff);
    rdc("wrap_hi", IDX_WRAP_HI, 8'hff);
    rdc("unmapped", 6'h05, 8'h00);
    wr(IDX_STAGING, 8'ha5);
    bus(1'b1, IDX_STAGING, 8'h3c, 4'h0);
    rdc("staging", IDX_STAGING, 8'ha5);
    wr(IDX_INT_EN, 8'hfc);
    rdc("int_enable", IDX_INT_EN, 8'h00);
    wr(IDX_CONTROL, 8'h06);
    rdc("status", IDX_STATUS, 8'h01);
    chk("corr_early", 8'h00, {7'h00, freq_correction_enable});
    wait_idle();
    chk("corr", 8'h01, {7'h00, freq_correction_enable});
    rdc("control", IDX_CONTROL, 8'h04);
    standby_sleep <= 1'b1;
    ctrl(8'h01);
    repeat (80) @(posedge clk);
    rdc("count_standby", IDX_COUNT_LO, 8'h00);
    ctrl(8'h81);
    repeat (80) @(posedge clk);
    bus(1'b0, IDX_COUNT_LO, 8'h00, 4'h1);
    chk("count_runs", 8'h01, {7'h00, rd !== 8'h00});
    standby_sleep <= 1'b0;
    ctrl(8'h00);
    wr(IDX_COUNT_LO, 8'h00);
    wr(IDX_COUNT_HI, 8'h00);
    rdc("status", IDX_STATUS, 8'h02);
    wait_idle();
    ctrl(8'h79);
    repeat (80) @(posedge clk);
    rdc("count_div", IDX_COUNT_LO, 8'h00);
    ctrl(8'h00);
    wr(IDX_WRAP_LO, 8'h03);
    wr(IDX_WRAP_HI, 8'h00);
    rdc("status", IDX_STATUS, 8'h04);
    wait_idle();
    wr(IDX_CMP_LO, 8'h02);
    wr(IDX_CMP_HI, 8'h00);
    rdc("status", IDX_STATUS, 8'h08);
    wait_idle();
    wr(IDX_COUNT_LO, 8'h00);
    wr(IDX_COUNT_HI, 8'h00);
    wait_idle();
    ctrl(8'h01);
    repeat (100) @(posedge clk);
    chk("irq_masked", 8'h00, {7'h00, irq});
    ctrl(8'h00);
    bus(1'b0, IDX_COUNT_LO, 8'h00, 4'h1);
    chk("count_bound", 8'h01, {7'h00, rd < 8'h04});
    rdc("int_flags", IDX_INT_FLAGS, 8'h03);
    wr(IDX_INT_EN, 8'h01);
    chk("irq_wrap", 8'h01, {7'h00, irq});
    wr(IDX_INT_FLAGS, 8'h01);
    rdc("int_flags", IDX_INT_FLAGS, 8'h02);
    chk("irq_cleared", 8'h00, {7'h00, irq});
    wr(IDX_INT_EN, 8'h02);
    chk("irq_cmp", 8'h01, {7'h00, irq});
    wr(IDX_INT_FLAGS, 8'h00);
    rdc("int_flags", IDX_INT_FLAGS, 8'h02);
    wr(IDX_INT_FLAGS, 8'h02);
    rdc("int_flags", IDX_INT_FLAGS, 8'h00);
    chk("irq_off", 8'h00, {7'h00, irq});
    conclude();
  end

endmodule : rtc_control_status_irq_regs_bench
`default_nettype wire

// ==== rtc_regs_pkg.sv ====
`default_nettype none
package rtc_regs_pkg;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index).
  // ---------------------------------------------------------------
  localparam logic [5:0] IDX_CONTROL   = 6'h00;
  localparam logic [5:0] IDX_STATUS    = 6'h01;
  localparam logic [5:0] IDX_INT_EN    = 6'h02;
  localparam logic [5:0] IDX_INT_FLAGS = 6'h03;
  localparam logic [5:0] IDX_STAGING   = 6'h04;
  localparam logic [5:0] IDX_COUNT_LO  = 6'h08;
  localparam logic [5:0] IDX_COUNT_HI  = 6'h09;
  localparam logic [5:0] IDX_WRAP_LO   = 6'h0a;
  localparam logic [5:0] IDX_WRAP_HI   = 6'h0b;
  localparam logic [5:0] IDX_CMP_LO    = 6'h0c;
  localparam logic [5:0] IDX_CMP_HI    = 6'h0d;

  // ---------------------------------------------------------------
  // Field positions and masks.
  // ---------------------------------------------------------------
  localparam int         CTRL_EN_BIT    = 0;
  localparam int         CTRL_CORR_BIT  = 2;
  localparam int         CTRL_PSC_LSB   = 3;
  localparam int         CTRL_PSC_MSB   = 6;
  localparam int         CTRL_STDBY_BIT = 7;
  localparam logic [7:0] CTRL_WMASK     = 8'hfd;
  localparam int         FLAG_WRAP      = 0;
  localparam int         FLAG_CMP       = 1;
  localparam int         PSC_W          = 15;

  // Indices of the four crossing channels, equal to their status bits.
  localparam int         SYN_CTRL = 0;
  localparam int         SYN_CNT  = 1;
  localparam int         SYN_WRAP = 2;
  localparam int         SYN_CMP  = 3;
  localparam int         SYN_N    = 4;

  // ---------------------------------------------------------------
  // Reset values and timing.
  // ---------------------------------------------------------------
  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] WRAP_RESET  = 16'hffff;
  localparam logic [15:0] CMP_RESET   = 16'h0000;
  localparam logic [1:0]  SYNC_TICKS  = 2'h2;

endpackage : rtc_regs_pkg
`default_nettype wire
